//--- hw/mpa_cfg.svh
// constants of the parameter access block: function codes, coil map, limits
// assumes inclusion by mpa_pkg users; definitions only
`ifndef MPA_CFG_SVH
`define MPA_CFG_SVH
`define MPA_FC_RD_COILS 8'h01
`define MPA_FC_RD_HOLD 8'h03
`define MPA_FC_WR_COIL 8'h05
`define MPA_FC_WR_REG 8'h06
`define MPA_FC_WR_COILS 8'h0F
`define MPA_FC_WR_REGS 8'h10
`define MPA_EXC_FLAG 8'h80
`define MPA_EXC_FUNC 8'h01
`define MPA_EXC_ADDR 8'h02
`define MPA_EXC_VALUE 8'h03
`define MPA_BCAST_ADDR 8'h00
`define MPA_COIL_ON 16'hFF00
`define MPA_COIL_OFF 16'h0000
`define MPA_COIL_CTRL_LO 7'h01
`define MPA_COIL_SPEED_LO 7'h11
`define MPA_COIL_STATUS_LO 7'h21
`define MPA_COIL_STORE 7'h41
`define MPA_COIL_LAST 17'h00041
`define MPA_IDX_REG 16'h0009
`define MPA_MAX_READ_REGS 16'h000A
`define MPA_MAX_TEXT 5'h14
`define MPA_SPACE 8'h20
`define MPA_REG_SPAN 17'h10000
`define MPA_PNU_SCALE 16'h000A
`define MPA_BUF_DEPTH 32
`endif

//--- hw/mpa_pkg.sv
// types of the parameter access block: sequencer states and the state record
// assumes nothing beyond a SystemVerilog compiler
package mpa_pkg;
   typedef enum logic [2:0] {
      ST_COLLECT, ST_EXEC, ST_COIL_RD, ST_COIL_WR, ST_PAR_RD, ST_PAR_WR, ST_REPLY
   } mpa_state_e;
   typedef struct packed {
      mpa_state_e st;
      logic [31:0][7:0] frame;
      logic [5:0] rxCnt;
      logic [5:0] txCnt;
      logic [5:0] txLen;
      logic bcast;
      logic [15:0] start;
      logic [15:0] qty;
      logic [6:0] idx;
      logic [15:0] idxPtr;
      logic [15:0] ctrlWord;
      logic [15:0] speedRef;
      logic storeSel;
      logic [7:0] txByte;
      logic txValid;
      logic txLast;
      logic parReq;
      logic parWe;
      logic [15:0] parNum;
      logic [3:0] parWord;
      logic [15:0] parWrData;
   } mpa_state_s;
endpackage : mpa_pkg

//--- hw/mpa_follower.sv
// follower-side command interpreter for coil and parameter access
// assumes a framer on ref_clk that strips the error check and flags it on rxEnd,
// a transmitter that appends the check, and a parameter store with req/ack
// Overview of operation
// (RL1) storage-select coil 65 set: writes go to non-volatile memory and RAM, else RAM
// (RL2) holding register 9 is the array index pointer used by all array accesses
// (RL3) text parameters accessed like others, text block at most 20 characters
// (RL4) read asking more characters than stored gets a reply cut to stored length
// (RL5) read asking fewer characters than stored gets space-filled reply bytes; here spaces fill only slots past the stored length and zero bytes
// (RL6) parameter values are exchanged as integers, scaled for fractions
// (RL7) integer and text parameters live in holding registers, read by function 03
// (RL8) master writes one register with function 6, two with function 10
// (RL9) master writes text parameters only with preset multiple registers
// (RL10) parameter reads of 1 to 10 registers are accepted
// (RL11) broadcast reads of any kind are ignored
// (RL12) telegram addresses are coil or register number minus one
// (RL13) read-coils reply packs one coil per bit, first coil in lsb of byte one
// (RL14) unused high bits of the last coil byte are zero
// (RL15) coil reply byte count equals the number of data bytes
// (RL16) drive status word is readable on coils 33 to 48
// (RL17) speed reference is taken from coils 17 to 32 when forced
// (RL18) single coil force data 00 00 means OFF and FF 00 means ON
// (RL19) single coil write is answered only after the coil changed
// (RL20) broadcast coil writes force the named coils here too
// (RL21) multiple coil reply carries address, function, start and quantity
// (RL22) register read reply sends two bytes per register, high byte first
// (RL23) parameter sits at holding register ten times its parameter number
// (RL24) start plus length outside the valid range gives exception 02
// (RL25) frames with a bad error check are dropped without reply
`timescale 1ns/1ps
`default_nettype none
`include "mpa_cfg.svh"
module mpa_follower (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // station address
   input wire logic [7:0] ownAddr,
   // received frame bytes from the framer
   input wire logic [7:0] rxByte,
   input wire logic rxValid,
   input wire logic rxEnd,
   input wire logic rxCrcOk,
   // reply bytes to the transmitter
   output logic [7:0] txByte,
   output logic txValid,
   output logic txLast,
   input wire logic txReady,
   // parameter store port
   output logic parReq,
   output logic parWe,
   output logic parNvm,
   output logic [15:0] parNum,
   output logic [3:0] parWord,
   output logic [15:0] parIdx,
   output logic [15:0] parWrData,
   input wire logic parAck,
   input wire logic parOk,
   input wire logic [15:0] parRdData,
   input wire logic [4:0] parTextLen,
   // drive side coils
   input wire logic [15:0] driveStatusWord,
   output logic [15:0] ctrlWord,
   output logic [15:0] speedRef
);
   logic [1:0] rstPipe_ff;
   logic rstSync_n;
   mpa_pkg::mpa_state_s r_ff;
   mpa_pkg::mpa_state_s nxt_r;

   // reset release through two flops, assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe_ff <= 2'h0;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe_ff[1];

   // coil value by coil number, unmapped coils read as zero
   function automatic logic coilGet(input mpa_pkg::mpa_state_s s, input logic [6:0] n);
      logic v;
      v = 1'b0;
      if (n >= `MPA_COIL_CTRL_LO && n < `MPA_COIL_SPEED_LO) begin
         v = s.ctrlWord[4'(n - `MPA_COIL_CTRL_LO)];
      end else if (n >= `MPA_COIL_SPEED_LO && n < `MPA_COIL_STATUS_LO) begin
         v = s.speedRef[4'(n - `MPA_COIL_SPEED_LO)];
      end else if (n >= `MPA_COIL_STATUS_LO && n < 7'(`MPA_COIL_STATUS_LO + 7'h10)) begin
         v = driveStatusWord[4'(n - `MPA_COIL_STATUS_LO)]; // RL16
      end else if (n == `MPA_COIL_STORE) begin
         v = s.storeSel;
      end
      return v;
   endfunction : coilGet

   // force one coil; status coils are read only and ignore writes
   function automatic mpa_pkg::mpa_state_s coilSet(input mpa_pkg::mpa_state_s s,
                                                  input logic [6:0] n, input logic v);
      mpa_pkg::mpa_state_s o;
      o = s;
      if (n >= `MPA_COIL_CTRL_LO && n < `MPA_COIL_SPEED_LO) begin
         o.ctrlWord[4'(n - `MPA_COIL_CTRL_LO)] = v;
      end else if (n >= `MPA_COIL_SPEED_LO && n < `MPA_COIL_STATUS_LO) begin
         o.speedRef[4'(n - `MPA_COIL_SPEED_LO)] = v; // RL17
      end else if (n == `MPA_COIL_STORE) begin
         o.storeSel = v;
      end
      return o;
   endfunction : coilSet

   // sequencer: collect, decode, coil loops, parameter loops, reply
   always_comb begin
      logic [15:0] regNum;
      logic [16:0] endRef;
      logic [15:0] forceVal;
      logic [7:0] excCode;
      logic [6:0] coilNum;
      logic [4:0] textLen;
      logic [4:0] dPos;
      logic [5:0] charPos;
      logic [7:0] hiB;
      logic [7:0] loB;
      regNum = 16'h0000;
      endRef = 17'h00000;
      forceVal = 16'h0000;
      excCode = 8'h00;
      coilNum = 7'h00;
      textLen = 5'h00;
      dPos = 5'h00;
      charPos = 6'h00;
      hiB = 8'h00;
      loB = 8'h00;
      nxt_r = r_ff;
      case (r_ff.st)
         mpa_pkg::ST_COLLECT: begin
            if (rxValid && r_ff.rxCnt < 6'(`MPA_BUF_DEPTH)) begin
               nxt_r.frame[5'(r_ff.rxCnt)] = rxByte;
               nxt_r.rxCnt = 6'(r_ff.rxCnt + 6'h01);
            end
            if (rxEnd) begin
               nxt_r.rxCnt = 6'h00;
               // bad check or foreign address: drop silently
               if (rxCrcOk && r_ff.rxCnt >= 6'h06 && (r_ff.frame[0] == ownAddr ||
                   r_ff.frame[0] == `MPA_BCAST_ADDR)) begin // RL25
                  nxt_r.st = mpa_pkg::ST_EXEC;
                  nxt_r.bcast = (r_ff.frame[0] == `MPA_BCAST_ADDR);
               end
            end
         end
         mpa_pkg::ST_EXEC: begin
            // telegram carries number minus one; loops add it back
            nxt_r.start = {r_ff.frame[2], r_ff.frame[3]}; // RL12
            nxt_r.qty = {r_ff.frame[4], r_ff.frame[5]};
            nxt_r.idx = 7'h00;
            nxt_r.txCnt = 6'h00;
            nxt_r.txLen = 6'h06; // RL21
            endRef = 17'(nxt_r.start) + 17'(nxt_r.qty);
            forceVal = nxt_r.qty;
            case (r_ff.frame[1])
               `MPA_FC_RD_COILS: begin
                  if (nxt_r.qty == 16'h0000 || 17'(nxt_r.qty) > `MPA_COIL_LAST) begin
                     excCode = `MPA_EXC_VALUE;
                  end else if (endRef > `MPA_COIL_LAST) begin
                     excCode = `MPA_EXC_ADDR; // RL24
                  end else begin
                     for (int b = 2; b < 13; b++) begin
                        nxt_r.frame[b] = 8'h00; // RL14
                     end
                     nxt_r.frame[2] = 8'(7'(nxt_r.qty[6:0] + 7'h07) >> 3); // RL15
                     nxt_r.txLen = 6'(6'h03 + nxt_r.frame[2][5:0]);
                     nxt_r.st = mpa_pkg::ST_COIL_RD;
                  end
               end
               `MPA_FC_RD_HOLD: begin
                  if (nxt_r.qty == 16'h0000 || nxt_r.qty > `MPA_MAX_READ_REGS) begin
                     excCode = `MPA_EXC_VALUE; // RL10
                  end else if (endRef > `MPA_REG_SPAN) begin
                     excCode = `MPA_EXC_ADDR; // RL24
                  end else begin
                     nxt_r.st = mpa_pkg::ST_PAR_RD; // RL7
                  end
               end
               `MPA_FC_WR_COIL: begin
                  if (forceVal != `MPA_COIL_ON && forceVal != `MPA_COIL_OFF) begin
                     excCode = `MPA_EXC_VALUE; // RL18
                  end else if (17'(nxt_r.start) >= `MPA_COIL_LAST) begin
                     excCode = `MPA_EXC_ADDR;
                  end else begin
                     // coil takes its state before the echo goes out
                     nxt_r = coilSet(nxt_r, 7'(nxt_r.start + 16'h0001),
                                     forceVal == `MPA_COIL_ON); // RL18 RL19
                     nxt_r.st = mpa_pkg::ST_REPLY;
                  end
               end
               `MPA_FC_WR_COILS: begin
                  if (nxt_r.qty == 16'h0000 || 17'(nxt_r.qty) > `MPA_COIL_LAST) begin
                     excCode = `MPA_EXC_VALUE;
                  end else if (endRef > `MPA_COIL_LAST) begin
                     excCode = `MPA_EXC_ADDR; // RL24
                  end else begin
                     nxt_r.st = mpa_pkg::ST_COIL_WR;
                  end
               end
               `MPA_FC_WR_REG: begin
                  nxt_r.qty = 16'h0001; // RL8
                  nxt_r.st = mpa_pkg::ST_PAR_WR;
               end
               `MPA_FC_WR_REGS: begin
                  if (nxt_r.qty == 16'h0000 || nxt_r.qty > `MPA_MAX_READ_REGS) begin
                     excCode = `MPA_EXC_VALUE;
                  end else if (endRef > `MPA_REG_SPAN) begin
                     excCode = `MPA_EXC_ADDR; // RL24
                  end else begin
                     nxt_r.st = mpa_pkg::ST_PAR_WR; // RL8 RL9
                  end
               end
               default: excCode = `MPA_EXC_FUNC;
            endcase
            if (excCode != 8'h00) begin
               nxt_r.frame[1] = r_ff.frame[1] | `MPA_EXC_FLAG;
               nxt_r.frame[2] = excCode;
               nxt_r.txLen = 6'h03;
               nxt_r.st = mpa_pkg::ST_REPLY;
            end
            // broadcasts never answer; reads do nothing at all
            if (r_ff.bcast && (excCode != 8'h00 || r_ff.frame[1] == `MPA_FC_RD_COILS ||
                r_ff.frame[1] == `MPA_FC_RD_HOLD || nxt_r.st == mpa_pkg::ST_REPLY)) begin
               nxt_r.st = mpa_pkg::ST_COLLECT; // RL11
            end
         end
         mpa_pkg::ST_COIL_RD: begin
            coilNum = 7'(r_ff.start + 16'(r_ff.idx) + 16'h0001);
            nxt_r.frame[5'(5'h03 + 5'(r_ff.idx[6:3]))][r_ff.idx[2:0]] =
               coilGet(r_ff, coilNum); // RL13
            nxt_r.idx = 7'(r_ff.idx + 7'h01);
            if (16'(nxt_r.idx) == r_ff.qty) begin
               nxt_r.st = mpa_pkg::ST_REPLY;
            end
         end
         mpa_pkg::ST_COIL_WR: begin
            coilNum = 7'(r_ff.start + 16'(r_ff.idx) + 16'h0001);
            nxt_r = coilSet(r_ff, coilNum,
                            r_ff.frame[5'(5'h07 + 5'(r_ff.idx[6:3]))][r_ff.idx[2:0]]); // RL20
            nxt_r.idx = 7'(r_ff.idx + 7'h01);
            if (16'(nxt_r.idx) == r_ff.qty) begin
               nxt_r.st = r_ff.bcast ? mpa_pkg::ST_COLLECT : mpa_pkg::ST_REPLY; // RL20
            end
         end
         mpa_pkg::ST_PAR_RD: begin
            regNum = 16'(r_ff.start + 16'(r_ff.idx) + 16'h0001);
            dPos = 5'(5'h03 + 5'({r_ff.idx[3:0], 1'b0}));
            charPos = 6'({r_ff.idx[4:0], 1'b0});
            textLen = (parTextLen > `MPA_MAX_TEXT) ? `MPA_MAX_TEXT : parTextLen; // RL3
            hiB = 8'h00;
            loB = 8'h00;
            if (regNum == `MPA_IDX_REG) begin
               {hiB, loB} = r_ff.idxPtr; // RL2
            end else if (!r_ff.parReq) begin
               nxt_r.parReq = 1'b1;
               nxt_r.parWe = 1'b0;
               nxt_r.parNum = 16'(regNum / `MPA_PNU_SCALE); // RL23
               nxt_r.parWord = 4'(regNum % `MPA_PNU_SCALE);
            end else if (parAck) begin
               nxt_r.parReq = 1'b0;
               {hiB, loB} = parRdData; // RL6
               if (textLen != 5'h00) begin
                  // unused character slots of a text read as spaces
                  if (hiB == 8'h00 || charPos >= 6'(textLen)) hiB = `MPA_SPACE; // RL5
                  if (loB == 8'h00 || 6'(charPos + 6'h01) >= 6'(textLen)) loB = `MPA_SPACE;
               end
            end
            if (regNum == `MPA_IDX_REG || (r_ff.parReq && parAck)) begin
               if (regNum != `MPA_IDX_REG && !parOk) begin
                  nxt_r.frame[1] = r_ff.frame[1] | `MPA_EXC_FLAG;
                  nxt_r.frame[2] = `MPA_EXC_ADDR; // RL24
                  nxt_r.txLen = 6'h03;
                  nxt_r.st = mpa_pkg::ST_REPLY;
               end else if (regNum != `MPA_IDX_REG && textLen != 5'h00 &&
                            charPos >= 6'(textLen)) begin
                  // asked beyond the stored text: reply stops here
                  nxt_r.frame[2] = 8'({r_ff.idx, 1'b0}); // RL4
                  nxt_r.txLen = 6'(dPos);
                  nxt_r.st = mpa_pkg::ST_REPLY;
               end else begin
                  nxt_r.frame[dPos] = hiB; // RL22
                  nxt_r.frame[5'(dPos + 5'h01)] = loB;
                  nxt_r.idx = 7'(r_ff.idx + 7'h01);
                  if (16'(nxt_r.idx) == r_ff.qty) begin
                     nxt_r.frame[2] = 8'({nxt_r.idx, 1'b0});
                     nxt_r.txLen = 6'(dPos + 5'h02);
                     nxt_r.st = mpa_pkg::ST_REPLY;
                  end
               end
            end
         end
         mpa_pkg::ST_PAR_WR: begin
            regNum = 16'(r_ff.start + 16'(r_ff.idx) + 16'h0001);
            dPos = (r_ff.frame[1] == `MPA_FC_WR_REG) ? 5'h04 :
                   5'(5'h07 + 5'({r_ff.idx[3:0], 1'b0}));
            if (regNum != `MPA_IDX_REG && !r_ff.parReq) begin
               nxt_r.parReq = 1'b1;
               nxt_r.parWe = 1'b1;
               nxt_r.parNum = 16'(regNum / `MPA_PNU_SCALE); // RL23
               nxt_r.parWord = 4'(regNum % `MPA_PNU_SCALE);
               nxt_r.parWrData = {r_ff.frame[dPos], r_ff.frame[5'(dPos + 5'h01)]};
            end
            if (regNum == `MPA_IDX_REG || (r_ff.parReq && parAck)) begin
               nxt_r.parReq = 1'b0;
               if (regNum == `MPA_IDX_REG) begin
                  nxt_r.idxPtr = {r_ff.frame[dPos], r_ff.frame[5'(dPos + 5'h01)]}; // RL2
               end
               nxt_r.idx = 7'(r_ff.idx + 7'h01);
               if (regNum != `MPA_IDX_REG && !parOk) begin
                  nxt_r.frame[1] = r_ff.frame[1] | `MPA_EXC_FLAG;
                  nxt_r.frame[2] = `MPA_EXC_ADDR; // RL24
                  nxt_r.txLen = 6'h03;
                  nxt_r.st = r_ff.bcast ? mpa_pkg::ST_COLLECT : mpa_pkg::ST_REPLY;
               end else if (16'(nxt_r.idx) == r_ff.qty) begin
                  nxt_r.st = r_ff.bcast ? mpa_pkg::ST_COLLECT : mpa_pkg::ST_REPLY;
               end
            end
         end
         mpa_pkg::ST_REPLY: begin
            // one byte offered, then a gap cycle; keeps the handshake simple
            if (!r_ff.txValid) begin
               nxt_r.txValid = 1'b1;
               nxt_r.txByte = r_ff.frame[5'(r_ff.txCnt)];
               nxt_r.txLast = (6'(r_ff.txCnt + 6'h01) == r_ff.txLen);
            end else if (txReady) begin
               nxt_r.txValid = 1'b0;
               nxt_r.txLast = 1'b0;
               nxt_r.txCnt = 6'(r_ff.txCnt + 6'h01);
               if (r_ff.txLast) nxt_r.st = mpa_pkg::ST_COLLECT;
            end
         end
         default: nxt_r.st = mpa_pkg::ST_COLLECT;
      endcase
   end

   // whole state in one register; reset loads constants only
   always_ff @(posedge ref_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         r_ff <= '0;
         r_ff.st <= mpa_pkg::ST_COLLECT;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // outputs straight from the state register
   assign txByte = r_ff.txByte;
   assign txValid = r_ff.txValid;
   assign txLast = r_ff.txLast;
   assign parReq = r_ff.parReq;
   assign parWe = r_ff.parWe;
   assign parNvm = r_ff.storeSel; // RL1
   assign parNum = r_ff.parNum;
   assign parWord = r_ff.parWord;
   assign parIdx = r_ff.idxPtr; // RL2
   assign parWrData = r_ff.parWrData;
   assign ctrlWord = r_ff.ctrlWord;
   assign speedRef = r_ff.speedRef;
endmodule : mpa_follower
`default_nettype wire

//--- testbench/mpa_follower_monitor.sv
// checker for the follower: reply handshake, store handshake, silence rules
// assumes it is bound to mpa_follower and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module mpa_follower_monitor (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // frame side
   input wire logic [7:0] rxByte,
   input wire logic rxValid,
   input wire logic rxEnd,
   input wire logic rxCrcOk,
   input wire logic [7:0] txByte,
   input wire logic txValid,
   input wire logic txLast,
   input wire logic txReady,
   // store and coil side
   input wire logic parReq,
   input wire logic parWe,
   input wire logic [15:0] parNum,
   input wire logic [3:0] parWord,
   input wire logic [15:0] parIdx,
   input wire logic parAck,
   input wire logic parNvm,
   input wire logic [15:0] ctrlWord,
   input wire logic [15:0] speedRef
);
   logic firstByte_ff;
   logic bcast_ff;
   // remember whether the frame now ending was addressed to everyone
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         firstByte_ff <= 1'b1;
         bcast_ff <= 1'b0;
      end else begin
         if (rxValid && firstByte_ff) bcast_ff <= (rxByte == 8'h00);
         if (rxValid || rxEnd) firstByte_ff <= rxEnd;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // a frame closes while no reply is going out
   sequence s_frameEnd;
      rxEnd && !txValid;
   endsequence
   // no reply byte for the next eight cycles
   sequence s_quiet;
      !txValid [*8];
   endsequence
   a_bad_check_silent: assert property ((s_frameEnd ##0 !rxCrcOk) |=> s_quiet)
      else $error("reply after a frame with a bad check");
   a_bcast_no_reply: assert property ((s_frameEnd ##0 bcast_ff) |=> s_quiet)
      else $error("reply to a broadcast frame");
   a_reply_not_early: assert property ((s_frameEnd ##0 rxCrcOk) |=> !txValid [*2])
      else $error("reply began sooner than three cycles");
   a_tx_byte_holds: assert property (txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast))
      else $error("reply byte changed while stalled");
   a_tx_gap_after: assert property (txValid && txReady |=> !txValid)
      else $error("no idle cycle after a taken byte");
   a_reply_end_quiet: assert property (txValid && txReady && txLast |=> !txValid [*3])
      else $error("bytes after the last reply byte");
   a_store_req_holds: assert property (parReq && !parAck |=> parReq && $stable({parNum, parWord, parIdx, parWe}))
      else $error("store request changed before its answer");
   a_store_req_drops: assert property (parReq && parAck |=> !parReq)
      else $error("store request held after its answer");
   a_coils_settled: assert property (txValid |-> $stable({ctrlWord, speedRef, parNvm}))
      else $error("coil outputs moved during a reply");
endmodule : mpa_follower_monitor
bind mpa_follower mpa_follower_monitor u_monitor (.ref_clk, .rst_n, .rxByte, .rxValid, .rxEnd,
   .rxCrcOk, .txByte, .txValid, .txLast, .txReady, .parReq, .parWe, .parNum, .parWord, .parIdx,
   .parAck, .parNvm, .ctrlWord, .speedRef);
`default_nettype wire

//--- testbench/mpa_master_model.sv
// bus master stand-in: hands frame bytes to the follower and takes reply bytes
// assumes the bench calls sendFrame only while no reply is pending
`timescale 1ns/1ps
`default_nettype none
module mpa_master_model (
   // clock
   input wire logic ref_clk,
   // frame bytes toward the follower
   output logic [7:0] rxByte,
   output logic rxValid,
   output logic rxEnd,
   output logic rxCrcOk,
   // reply acceptance
   output logic txReady
);
   integer seed = 32'h6568;
   initial begin
      rxByte = 8'hA5;
      rxValid = 1'b0;
      rxEnd = 1'b0;
      rxCrcOk = 1'b0;
   end
   // random stalls so replies meet both prompt and slow takers
   always @(negedge ref_clk) txReady <= 1'($random(seed));
   // f goes out from byte n-1 down to 0; the line shows the inverse between bytes
   task automatic sendFrame(input logic [11:0][7:0] f, input int n, input logic ok);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge ref_clk);
         rxByte = f[i];
         rxValid = 1'b1;
         @(negedge ref_clk);
         rxValid = 1'b0;
         rxByte = ~f[i];
      end
      @(negedge ref_clk);
      rxEnd = 1'b1;
      rxCrcOk = ok;
      @(negedge ref_clk);
      rxEnd = 1'b0;
      rxCrcOk = ~ok;
   endtask : sendFrame
endmodule : mpa_master_model
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench: frames go in through the master model, replies are matched
// assumes the follower, master model and bound monitor are compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] rxByte, txByte;
   logic rxValid, rxEnd, rxCrcOk, txValid, txLast, txReady, parReq, parWe, parNvm;
   logic parAck = 1'b0;
   logic parOk = 1'b0;
   logic [15:0] parNum, parIdx, parWrData, ctrlWord, speedRef, v, lastWr;
   logic [15:0] parRdData = 16'h0000;
   logic [15:0] drive_status_word = 16'h0000;
   logic [3:0] parWord;
   logic [4:0] parTextLen = 5'h00;
   logic [4:0] textLen = 5'h00;
   logic [8:0] expQ[$];
   integer seed = 32'h6568;
   int miscompares = 0;
   int cmp_count = 0;
   int cycles = 0;
   always #10 ref_clk = ~ref_clk;
   mpa_master_model master (.ref_clk(ref_clk), .rxByte(rxByte), .rxValid(rxValid),
      .rxEnd(rxEnd), .rxCrcOk(rxCrcOk), .txReady(txReady));
   mpa_follower DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ownAddr(8'h11), .rxByte(rxByte),
      .rxValid(rxValid), .rxEnd(rxEnd), .rxCrcOk(rxCrcOk), .txByte(txByte), .txValid(txValid),
      .txLast(txLast), .txReady(txReady), .parReq(parReq), .parWe(parWe), .parNvm(parNvm),
      .parNum(parNum), .parWord(parWord), .parIdx(parIdx), .parWrData(parWrData),
      .parAck(parAck), .parOk(parOk), .parRdData(parRdData), .parTextLen(parTextLen),
      .driveStatusWord(drive_status_word), .ctrlWord(ctrlWord), .speedRef(speedRef));
   // store stand-in: slow on some cycles; text words hold letters, integers echo the request
   always @(negedge ref_clk) begin
      parAck <= parReq & (cycles[1:0] != 2'b00);
      parOk <= (parNum != 16'h03E7);
      if (parReq && parWe) lastWr <= parWrData;
      parTextLen <= textLen;
      parRdData <= (textLen != 5'h00) ? {8'h41 + {3'h0, parWord, 1'b0}, 8'h42 + {3'h0, parWord, 1'b0}}
         : {parNum[7:0], parIdx[3:0], parWord};
   end
   task automatic checkByte(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : checkByte
   task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : checkWord
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   // reply watcher: each taken byte meets the oldest note, a byte with no note fails
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (txValid === 1'b1 && txReady === 1'b1) begin
         if (expQ.size() == 0) checkByte({txLast, txByte}, 9'bx);
         else checkByte({txLast, txByte}, expQ.pop_front());
      end
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   // notes the reply, sends the frame, waits for the reply or long enough for silence
   task automatic xfer(input logic [11:0][7:0] f, input int nf, input logic ok,
      input logic [15:0][7:0] e, input int ne);
      for (int i = ne - 1; i >= 0; i--) expQ.push_back({i == 0, e[i]});
      master.sendFrame(f, nf, ok);
      for (int i = 0; i < 400 && (expQ.size() != 0 || i < 80); i++) @(negedge ref_clk);
      // a reply that never came must not pass quietly
      if (expQ.size() != 0) begin
         miscompares++;
         expQ.delete();
      end
   endtask : xfer
   initial begin
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      // storage select forced on, then off; then a force value that is refused
      for (int k = 0; k < 2; k++) begin
         v = k ? 16'h0000 : 16'hFF00;
         xfer({8'h11, 8'h05, 16'h0040, v}, 6, 1'b1, {8'h11, 8'h05, 16'h0040, v}, 6);
         checkWord({15'h0000, parNvm}, {15'h0000, v[15]});
      end
      xfer({8'h11, 8'h05, 16'h0040, 16'h1234}, 6, 1'b1, {8'h11, 8'h85, 8'h03}, 3);
      // speed coils forced addressed, then control coils by broadcast with no reply
      for (int k = 0; k < 2; k++) begin
         v = 16'($random(seed));
         xfer({k ? 8'h00 : 8'h11, 8'h0F, 16'(16 - 16 * k), 16'h0010, 8'h02, v[7:0], v[15:8]}, 9,
            1'b1, {8'h11, 8'h0F, 16'h0010, 16'h0010}, k ? 0 : 6);
         checkWord(k ? ctrlWord : speedRef, v);
      end
      // status coils read with 1, 8 and 15 coils; a broadcast read gets nothing
      for (int k = 1; k <= 16; k += 7) begin
         drive_status_word = 16'($random(seed));
         v = drive_status_word & 16'((17'h00001 << k) - 17'h00001);
         xfer({8'h11, 8'h01, 16'h0020, 16'(k)}, 6, 1'b1, {8'h11, 8'h01, (k > 8) ? 8'h02 : 8'h01,
            v[7:0], v[15:8]} >> ((k > 8) ? 0 : 8), (k > 8) ? 5 : 4);
      end
      xfer({8'h00, 8'h01, 16'h0020, 16'h0010}, 6, 1'b1, 128'h0, 0);
      // index pointer set, read back, then used by a two-register parameter read
      v = 16'($random(seed));
      xfer({8'h11, 8'h06, 16'h0008, v}, 6, 1'b1, {8'h11, 8'h06, 16'h0008, v}, 6);
      xfer({8'h11, 8'h03, 16'h0008, 16'h0001}, 6, 1'b1, {8'h11, 8'h03, 8'h02, v}, 5);
      xfer({8'h11, 8'h03, 16'h0C2F, 16'h0002}, 6, 1'b1, {8'h11, 8'h03, 8'h04, 8'h38,
         v[3:0], 4'h0, 8'h38, v[3:0], 4'h1}, 7);
      // two-register write reaches the store; a register the store lacks gives 02
      xfer({8'h11, 8'h10, 16'h0C2F, 16'h0002, 8'h04, v, ~v}, 11, 1'b1,
         {8'h11, 8'h10, 16'h0C2F, 16'h0002}, 6);
      checkWord(lastWr, ~v);
      xfer({8'h11, 8'h03, 16'h2705, 16'h0001}, 6, 1'b1, {8'h11, 8'h83, 8'h02}, 3);
      // five stored characters read as eight: cut after the third word, gap filled
      textLen = 5'h05;
      xfer({8'h11, 8'h03, 16'h0009, 16'h0004}, 6, 1'b1,
         {8'h11, 8'h03, 8'h06, 40'h4142434445, 8'h20}, 9);
      textLen = 5'h00;
      xfer({8'h11, 8'h03, 16'h0009, 16'h000B}, 6, 1'b1, {8'h11, 8'h83, 8'h03}, 3);
      xfer({8'h11, 8'h03, 16'hFFFF, 16'h0002}, 6, 1'b1, {8'h11, 8'h83, 8'h02}, 3);
      xfer({8'h11, 8'h03, 16'h0008, 16'h0001}, 6, 1'b0, 128'h0, 0);
      summarize();
   end
endmodule : testbench
`default_nettype wire
